// ---- bench/drive_alarm_supervisor_tb_top.sv ----
// Self-checking bench for the drive alarm supervisor
`timescale 1ns/1ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end

module drive_alarm_supervisor_tb_top
    import alarm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, drive_ok_output, sequencer_hold_state;
    logic health_lamp, external_stop_pin, run_command_input;
    logic at_zero_speed, at_zero_setpoint, sys_alarm_valid;
    logic [15:0] fault_pins, armature_current, sys_alarm_code, health_word;
    logic signed [15:0] speed_feedback, armature_voltage;
    int n_fail = 0, checked = 0, cycles = 0;

    // Short tick keeps the timers to tens of cycles
    drive_alarm_supervisor #(.TICK_LEN(10)) i_dut (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fault_pins, .external_stop_pin,
        .run_command_input, .armature_current, .speed_feedback,
        .armature_voltage, .at_zero_speed, .at_zero_setpoint,
        .sys_alarm_valid, .sys_alarm_code, .drive_ok_output,
        .sequencer_hold_state, .health_lamp, .health_word
    );
    drive_side_model i_drv (
        .clk, .fault_pins, .external_stop_pin, .run_command_input,
        .armature_current, .speed_feedback, .armature_voltage,
        .at_zero_speed, .at_zero_setpoint, .sys_alarm_valid, .sys_alarm_code
    );

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////
    // One APB transfer; waits on pready, only the hang guard bounds it
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        xfer(1'b1, a, {16'h0000, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h00000000, q);
        `CHK(q, {16'h0000, e})
    endtask
    task automatic st(input logic [15:0] m, input logic [15:0] e);
        logic [31:0] q;
        xfer(1'b0, OFS_STATUS, 32'h00000000, q);
        `CHK(q[15:0] & m, e)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Policy low then high: the edge is what clears
    task automatic clr(input logic [7:0] c);
        wr(OFS_CTRL, {8'h00, c & 8'hF7});
        wr(OFS_CTRL, {8'h00, c | 8'h08});
    endtask
    task automatic run_pulse;
        i_drv.pins(16'h0000, external_stop_pin, 1'b0);
        wt(5);
        i_drv.pins(16'h0000, external_stop_pin, 1'b1);
        wt(5);
    endtask
    task automatic give_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            give_verdict;
        end
    end

    initial
    begin
        wt(4);
        rst_b <= 1'b1;
        rd(OFS_CTRL, {8'h00, CTL_RESET});
        rd(OFS_STOP_DELAY, STOP_DELAY_RESET);
        rd(OFS_STALL_LEVEL, STALL_LEVEL_RESET);
        rd(OFS_STALL_DELAY, STALL_DELAY_RESET);
        rd(OFS_MISMATCH_LEVEL, MISMATCH_LEVEL_RESET);
        rd(8'h24, 16'h0000);
        st(16'h007F, 16'h0024);
        // Field and encoder inhibited; peer enable off but link still master, so peer alarm counts
        clr(8'h5C);
        i_drv.pins(16'h0980, 1'b0, 1'b1);
        wt(5);
        rd(OFS_HEALTH_WORD, 16'h0800);
        clr(8'hDC);
        wt(3);
        rd(OFS_HEALTH_WORD, 16'h0000);
        rd(OFS_FIRST_FAULT, 16'h0000);
        // Policy false: two alarms, stop, restart, still latched
        i_drv.pins(16'h0000, 1'b0, 1'b1);
        wr(OFS_CTRL, 16'h0077);
        i_drv.pins(16'h0100, 1'b0, 1'b1);
        wt(5);
        i_drv.pins(16'h0110, 1'b0, 1'b1);
        wt(5);
        rd(OFS_HEALTH_WORD, 16'h0110);
        rd(OFS_FIRST_FAULT, 16'h0100);
        rd(OFS_LAST_FAULT, 16'h0010);
        st(16'h0025, 16'h0001);
        run_pulse();
        st(16'h0021, 16'h0000);
        rd(OFS_HEALTH_WORD, 16'h0110);
        i_drv.pins(16'h0000, 1'b0, 1'b0);
        wt(5);
        st(16'h0040, 16'h0040);
        wr(OFS_CTRL, {8'h00, CTL_RESET});
        wt(3);
        rd(OFS_HEALTH_WORD, 16'h0000);
        rd(OFS_FIRST_FAULT, 16'h0000);
        st(16'h0060, 16'h0020);
        // Policy true: run edge clears; pins 6, 12 and 14 never count
        i_drv.pins(16'h5041, 1'b0, 1'b1);
        wt(5);
        rd(OFS_HEALTH_WORD, 16'h0001);
        rd(OFS_FIRST_FAULT, 16'h0001);
        run_pulse();
        rd(OFS_HEALTH_WORD, 16'h0000);
        // System codes are whole words and stay out of the health word
        i_drv.sys(CODE_AUTOTUNE);
        i_drv.sys(CODE_PRODUCT);
        wt(2);
        rd(OFS_FIRST_FAULT, CODE_AUTOTUNE);
        rd(OFS_LAST_FAULT, CODE_PRODUCT);
        rd(OFS_HEALTH_WORD, 16'h0000);
        `CHK(drive_ok_output, 1'b0)
        run_pulse();
        // Stall: threshold is strict, setpoint blocks, delay of 3 ticks
        wr(OFS_STALL_DELAY, 16'h0003);
        i_drv.meas(16'h251C, 16'sh0000, 16'sh0000, 1'b1, 1'b0);
        wt(40);
        st(16'h0008, 16'h0000);
        i_drv.meas(16'h251D, 16'sh0000, 16'sh0000, 1'b1, 1'b1);
        wt(40);
        st(16'h0008, 16'h0000);
        i_drv.meas(16'h251D, 16'sh0000, 16'sh0000, 1'b1, 1'b0);
        wt(12);
        st(16'h0008, 16'h0000);
        wt(30);
        st(16'h0028, 16'h0008);
        rd(OFS_HEALTH_WORD, 16'h1000);
        wr(OFS_CTRL, 16'h007B);
        run_pulse();
        st(16'h0028, 16'h0028);
        // Mismatch: level 50.0 is strict; flag runs while inhibited
        i_drv.meas(16'h0000, 16'sh0258, 16'sh0064, 1'b0, 1'b0);
        wt(5);
        st(16'h0022, 16'h0020);
        i_drv.meas(16'h0000, 16'sh0259, 16'sh0064, 1'b0, 1'b0);
        wt(5);
        rd(OFS_HEALTH_WORD, 16'h0040);
        wr(OFS_CTRL, 16'h006F);
        run_pulse();
        rd(OFS_HEALTH_WORD, 16'h0000);
        st(16'h0022, 16'h0022);
        i_drv.meas(16'h0000, 16'sh0000, 16'sh0000, 1'b0, 1'b0);
        // Remote trip after 2 ticks, then inhibited
        wr(OFS_STOP_DELAY, 16'h0002);
        wr(OFS_CTRL, 16'h007F);
        i_drv.pins(16'h0000, 1'b1, 1'b1);
        wt(6);
        st(16'h0030, 16'h0020);
        wt(30);
        st(16'h0030, 16'h0010);
        rd(OFS_LAST_FAULT, CODE_REMOTE_TRIP);
        i_drv.pins(16'h0000, 1'b0, 1'b1);
        wr(OFS_CTRL, 16'h003F);
        run_pulse();
        i_drv.pins(16'h0000, 1'b1, 1'b1);
        wt(40);
        st(16'h0030, 16'h0030);
        give_verdict();
    end
endmodule // drive_alarm_supervisor_tb_top

// ---- bench/drive_side_model.sv ----
// Behavioural drive side: fault sensors, sequencer and run command
`timescale 1ns/1ps

module drive_side_model (
    // Clock
    input wire logic clk,
    // Toward the supervisor
    output logic [15:0] fault_pins,
    output logic external_stop_pin,
    output logic run_command_input,
    output logic [15:0] armature_current,
    output logic signed [15:0] speed_feedback,
    output logic signed [15:0] armature_voltage,
    output logic at_zero_speed,
    output logic at_zero_setpoint,
    output logic sys_alarm_valid,
    output logic [15:0] sys_alarm_code
);
    // Quiet running drive at time zero
    initial
    begin
        fault_pins = 16'h0000;
        external_stop_pin = 1'b0;
        run_command_input = 1'b1;
        sys_alarm_valid = 1'b0;
        sys_alarm_code = 16'hFFFF;
    end
    // Levels change just after an edge, as the sequencer does
    task automatic pins(input logic [15:0] p, input logic s, input logic r);
        @(posedge clk);
        fault_pins <= p;
        external_stop_pin <= s;
        run_command_input <= r;
    endtask
    task automatic meas(input logic [15:0] i, input logic signed [15:0] s,
        input logic signed [15:0] v, input logic zs, input logic zr);
        @(posedge clk);
        armature_current <= i;
        speed_feedback <= s;
        armature_voltage <= v;
        at_zero_speed <= zs;
        at_zero_setpoint <= zr;
    endtask
    // One-cycle event; code scrambled once invalid so it is not reused
    task automatic sys(input logic [15:0] c);
        @(posedge clk);
        sys_alarm_valid <= 1'b1;
        sys_alarm_code <= c;
        @(posedge clk);
        sys_alarm_valid <= 1'b0;
        sys_alarm_code <= ~c;
    endtask
    initial
        meas(16'h0000, 16'sh0000, 16'sh0000, 1'b0, 1'b0);
endmodule // drive_side_model

// ---- bench/supervisor_checker_asserts.sv ----
// Port-level assertions for the drive alarm supervisor
`timescale 1ns/1ps

module supervisor_checker
    import alarm_pkg::*;
#(
    parameter int TICK_LEN = 10
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Drive side
    input wire logic run_command_input,
    input wire logic drive_ok_output,
    input wire logic sequencer_hold_state,
    input wire logic health_lamp,
    input wire logic [15:0] health_word
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Stopped with a fault; four samples cover the pin synchroniser
    sequence s_stopped;
        (!run_command_input && !drive_ok_output && !psel) [*4];
    endsequence
    // No write and no run edge, long enough to flush a late clear
    sequence s_quiet;
        (!psel && !run_command_input) [*5];
    endsequence

    property p_rdy;
        pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_bad;
        psel && penable && paddr > OFS_LAST_FAULT |-> pslverr;
    endproperty
    a_bad: assert property (p_bad) else $error("no pslverr");
    property p_idle;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_idle: assert property (p_idle) else $error("stray pslverr");
    property p_b14;
        health_word[14] == 1'b0;
    endproperty
    a_b14: assert property (p_b14) else $error("bit 14 set");
    property p_okw;
        health_word != 16'h0000 |-> !drive_ok_output;
    endproperty
    a_okw: assert property (p_okw) else $error("ok with fault");
    property p_lamp;
        health_lamp == drive_ok_output;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp differs");
    property p_hold;
        s_stopped |=> sequencer_hold_state;
    endproperty
    a_hold: assert property (p_hold) else $error("no hold");
    // Stored bits may only drop through a clear
    property p_latch;
        s_quiet |=>
            (health_word & $past(health_word)) == $past(health_word);
    endproperty
    a_latch: assert property (p_latch) else $error("alarm lost");
endmodule // supervisor_checker

////////////////////////////////////////////////////////////
bind drive_alarm_supervisor supervisor_checker
    #(.TICK_LEN(TICK_LEN)) i_chk (
    .clk, .rst_b, .psel, .penable, .paddr, .pready, .pslverr,
    .run_command_input, .drive_ok_output, .sequencer_hold_state,
    .health_lamp, .health_word
);

// ---- core/drive_alarm_supervisor.sv ----
// Fault supervisor: inhibits, latching, clear policy, timers, APB registers
//
// How it works
// - Field loss inhibit suppresses field alarm
// - Peer receive inhibit applies only in slave
// - Stall inhibit keeps contactor closed
// - Policy false: faults stay latched, and drive_ok_output stays low
// - Stopped with stored fault: sequencer holds
// - Policy rising false to true clears faults
// - Policy true: run command clears faults
// - Mismatch inhibit suppresses mismatch alarm
// - Encoder inhibit suppresses encoder alarm
// - Remote trip after programmable delay, inhibitable
// - Stall: current high, zero speed, setpoint
// - Stall output after condition persists delay
// - Mismatch when speed and voltage differ by more than level
// - Mismatch flag tracks even when inhibited
// - Thermistor flag follows thermistor input
// - Health word ors all stored hardware alarms
// - First fault code kept from capture until a clear
// - Last fault holds most recent code
// - Hardware alarm codes are one-hot
// - System alarms use whole 16-bit codes
// - Lamp flag mirrors the health lamp
// - Remote trip flag shows trip state
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module drive_alarm_supervisor
    import alarm_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous fault pins, one per one-hot code
    input wire logic [15:0] fault_pins,
    input wire logic external_stop_pin,
    input wire logic run_command_input,
    // Measurements from the drive core, same clock
    input wire logic [15:0] armature_current,
    input wire logic signed [15:0] speed_feedback,
    input wire logic signed [15:0] armature_voltage,
    input wire logic at_zero_speed,
    input wire logic at_zero_setpoint,
    // System alarms from the sequencer, same clock
    input wire logic sys_alarm_valid,
    input wire logic [15:0] sys_alarm_code,
    // Drive outputs
    output logic drive_ok_output,
    output logic sequencer_hold_state,
    output logic health_lamp,
    output logic [15:0] health_word
);

    ////////////////////////////////////////////////////////////////////////
    // Lowest set bit as its one-hot code; keeps first-fault deterministic
    function automatic logic [15:0] lowest_one(input logic [15:0] v);
        lowest_one = v & (~v + 16'h0001);
    endfunction

    logic [CTL_W-1:0] ctrl;
    logic [15:0] external_stop_delay;
    logic [15:0] stall_level;
    logic [15:0] stall_delay;
    logic [15:0] velocity_mismatch_level;
    logic [15:0] pins_meta;
    logic [15:0] pins_sync;
    logic [1:0] ctl_meta;
    logic [1:0] ctl_sync;
    logic run_prev;
    logic policy_prev;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] stall_cnt;
    logic [15:0] stop_cnt;
    logic stall_out;
    logic stop_out;
    logic [15:0] stored_bits;
    logic sys_stored;
    logic [15:0] first_fault;
    logic first_valid;
    logic [15:0] last_fault;
    logic [31:0] rd_hold;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; first stage read only by the second
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pins_meta <= 16'h0000;
            pins_sync <= 16'h0000;
            ctl_meta <= 2'h0;
            ctl_sync <= 2'h0;
        end
        else
        begin
            pins_meta <= fault_pins;
            pins_sync <= pins_meta;
            ctl_meta <= {external_stop_pin, run_command_input};
            ctl_sync <= ctl_meta;
        end
    end

    // Synchronised remote trip request and run command levels
    wire stop_req = ctl_sync[1];
    wire run_in = ctl_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // Tenth-of-second tick shared by both delay timers
    // Free running, so a timer may see its first tick early
    wire tick_wrap = (tick_cnt == 32'(TICK_LEN - 1));

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            tick <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stall comparator and mismatch comparator
    wire stall_cond = (armature_current > stall_level) && at_zero_speed
        && !at_zero_setpoint;
    wire signed [16:0] vel_diff = 17'(speed_feedback) - 17'(armature_voltage);
    wire [16:0] vel_abs = vel_diff[16] ? 17'(-vel_diff) : 17'(vel_diff);
    // Flag ignores the inhibit so software still sees the condition
    wire mismatch = vel_abs > {1'b0, velocity_mismatch_level};

    // Persistence timers count ticks while their condition holds
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            stall_cnt <= 16'h0000;
            stop_cnt <= 16'h0000;
        end
        else
        begin
            if (!stall_cond)
                stall_cnt <= 16'h0000;
            else if (tick && !stall_out)
                stall_cnt <= stall_cnt + 16'h0001;
            if (!stop_req)
                stop_cnt <= 16'h0000;
            else if (tick && !stop_out)
                stop_cnt <= stop_cnt + 16'h0001;
        end
    end

    // Zero delay setting behaves as the shortest tick
    assign stall_out = stall_cond && (stall_cnt >= stall_delay)
        && (stall_cnt != 16'h0000);
    assign stop_out = stop_req && (stop_cnt >= external_stop_delay)
        && (stop_cnt != 16'h0000);

    ////////////////////////////////////////////////////////////////////////
    // Present alarms after inhibits, one bit per code
    wire peer_block = ctrl[CTL_PEER_SLAVE] && !ctrl[CTL_PEER_EN];
    wire [15:0] gate_mask = ~(
        (16'(!ctrl[CTL_FIELD_EN]) << BIT_FIELD)
        | (16'(peer_block) << BIT_PEER_RX)
        | (16'(!ctrl[CTL_ENCODER_EN]) << BIT_ENCODER));
    // Alarms made here rather than by pins: stall timer and mismatch
    wire [15:0] made_bits =
        (16'(stall_out && ctrl[CTL_STALL_EN]) << BIT_STALL)
        | (16'(mismatch && ctrl[CTL_MISMATCH_EN]) << BIT_MISMATCH);
    wire [15:0] hw_now = (pins_sync & PIN_MASK & gate_mask)
        | made_bits;
    wire stop_alarm = stop_out && ctrl[CTL_STOP_EN];

    // New events: fresh hardware bits first, then remote trip, then system
    wire [15:0] hw_new = hw_now & ~stored_bits;
    wire new_hw = |hw_new;
    wire new_stop = stop_alarm && !sys_stored;
    wire new_sys = sys_alarm_valid && (sys_alarm_code != CODE_NONE);
    wire any_new = new_hw || new_stop || new_sys;
    wire [15:0] new_code = new_hw ? lowest_one(hw_new)
        : new_stop ? CODE_REMOTE_TRIP
        : sys_alarm_code;

    ////////////////////////////////////////////////////////////////////////
    // Clear events: policy rising, or run edge while policy set
    wire policy = ctrl[CTL_CLEAR_POLICY];
    wire clear_evt = (policy && !policy_prev)
        || (policy && run_in && !run_prev);

    // Edge history; policy starts set, so leaving reset is no false rise
    // A run held high through reset gives one harmless early clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            run_prev <= 1'b0;
            policy_prev <= 1'b1;
        end
        else
        begin
            run_prev <= run_in;
            policy_prev <= policy;
        end
    end

    // Latched faults; new alarms win over a clear in the same cycle
    // A hardware alarm still present at a clear stays stored, not new again
    wire [15:0] next_stored = (clear_evt ? 16'h0000 : stored_bits)
        | hw_now;
    wire next_sys = (clear_evt ? 1'b0 : sys_stored)
        | new_stop | new_sys;
    wire next_any = (|next_stored) || next_sys;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            stored_bits <= 16'h0000;
            sys_stored <= 1'b0;
        end
        else
        begin
            stored_bits <= next_stored;
            sys_stored <= next_sys;
        end
    end

    // First and last fault capture
    // A clear with no new alarm empties first fault; last fault is kept
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            first_fault <= CODE_NONE;
            first_valid <= 1'b0;
            last_fault <= CODE_NONE;
        end
        else
        begin
            if (any_new && (!first_valid || clear_evt))
            begin
                first_fault <= new_code;
                first_valid <= 1'b1;
            end
            else if (clear_evt)
            begin
                first_fault <= CODE_NONE;
                first_valid <= 1'b0;
            end
            if (any_new)
                last_fault <= new_code;
        end
    end

    // Drive_ok_output path and sequencer hold
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            drive_ok_output <= 1'b1;
            sequencer_hold_state <= 1'b0;
        end
        else
        begin
            drive_ok_output <= !next_any;
            sequencer_hold_state <= next_any
                && (sequencer_hold_state || !run_in);
        end
    end

    // Lamp follows drive_ok_output; health word shows latched alarms only
    assign health_lamp = drive_ok_output;
    assign health_word = stored_bits;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; every access completes with no wait state
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_stop = (paddr == OFS_STOP_DELAY);
    wire hit_slvl = (paddr == OFS_STALL_LEVEL);
    wire hit_sdly = (paddr == OFS_STALL_DELAY);
    wire hit_mlvl = (paddr == OFS_MISMATCH_LEVEL);
    wire hit_stat = (paddr == OFS_STATUS);
    wire hit_hw = (paddr == OFS_HEALTH_WORD);
    wire hit_ff = (paddr == OFS_FIRST_FAULT);
    wire hit_lf = (paddr == OFS_LAST_FAULT);
    wire mapped = hit_ctrl || hit_stop || hit_slvl || hit_sdly || hit_mlvl
        || hit_stat || hit_hw || hit_ff || hit_lf;

    // Condition flags are raw: inhibits never hide them; lamp, ok and hold follow gated alarms
    wire [6:0] status_bits = {
        sequencer_hold_state,
        drive_ok_output,
        stop_out,
        stall_out,
        health_lamp,
        mismatch,
        pins_sync[BIT_THERMISTOR]
    };

    // Unmapped offsets read as zero
    wire [31:0] rd_mux =
        hit_ctrl ? {24'h000000, ctrl}
        : hit_stop ? {16'h0000, external_stop_delay}
        : hit_slvl ? {16'h0000, stall_level}
        : hit_sdly ? {16'h0000, stall_delay}
        : hit_mlvl ? {16'h0000, velocity_mismatch_level}
        : hit_stat ? {25'h0000000, status_bits}
        : hit_hw ? {16'h0000, health_word}
        : hit_ff ? {16'h0000, first_fault}
        : hit_lf ? {16'h0000, last_fault}
        : 32'h0000_0000;

    // Settings registers
    // Any value is taken; a zero delay still waits one tick
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl <= CTL_RESET;
            external_stop_delay <= STOP_DELAY_RESET;
            stall_level <= STALL_LEVEL_RESET;
            stall_delay <= STALL_DELAY_RESET;
            velocity_mismatch_level <= MISMATCH_LEVEL_RESET;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl <= pwdata[CTL_W-1:0];
            if (hit_stop)
                external_stop_delay <= pwdata[15:0];
            if (hit_slvl)
                stall_level <= pwdata[15:0];
            if (hit_sdly)
                stall_delay <= pwdata[15:0];
            if (hit_mlvl)
                velocity_mismatch_level <= pwdata[15:0];
        end
    end

    // Read data captured in the setup cycle, held through access
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rd_hold <= 32'h0000_0000;
        else if (setup)
            rd_hold <= rd_mux;
    end

    // Zero wait states; an unmapped access answers with an error
    assign prdata = rd_hold;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

endmodule // drive_alarm_supervisor

// ---- inc/alarm_pkg.sv ----
// Shared constants for the drive alarm supervisor
package alarm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STOP_DELAY = 8'h04;
    localparam logic [7:0] OFS_STALL_LEVEL = 8'h08;
    localparam logic [7:0] OFS_STALL_DELAY = 8'h0C;
    localparam logic [7:0] OFS_MISMATCH_LEVEL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_HEALTH_WORD = 8'h18;
    localparam logic [7:0] OFS_FIRST_FAULT = 8'h1C;
    localparam logic [7:0] OFS_LAST_FAULT = 8'h20;
    // Control register bit positions
    localparam int CTL_FIELD_EN = 0;
    localparam int CTL_PEER_EN = 1;
    localparam int CTL_STALL_EN = 2;
    localparam int CTL_CLEAR_POLICY = 3;
    localparam int CTL_MISMATCH_EN = 4;
    localparam int CTL_ENCODER_EN = 5;
    localparam int CTL_STOP_EN = 6;
    localparam int CTL_PEER_SLAVE = 7;
    localparam int CTL_W = 8;
    localparam logic [7:0] CTL_RESET = 8'h7F;
    // Status register bit positions
    localparam int ST_THERMISTOR = 0;
    localparam int ST_MISMATCH = 1;
    localparam int ST_LAMP = 2;
    localparam int ST_STALL = 3;
    localparam int ST_STOP = 4;
    localparam int ST_DRIVE_OK = 5;
    localparam int ST_HOLD = 6;
    // Setting reset values (0.1 s and 0.01 % / 0.1 % units)
    localparam logic [15:0] STOP_DELAY_RESET = 16'h0064;
    localparam logic [15:0] STALL_LEVEL_RESET = 16'h251C;
    localparam logic [15:0] STALL_DELAY_RESET = 16'h012C;
    localparam logic [15:0] MISMATCH_LEVEL_RESET = 16'h01F4;
    // Alarm bit positions in the one-hot code space
    localparam int BIT_THERMISTOR = 4;
    localparam int BIT_MISMATCH = 6;
    localparam int BIT_ENCODER = 7;
    localparam int BIT_FIELD = 8;
    localparam int BIT_PEER_RX = 11;
    localparam int BIT_STALL = 12;
    // Pins that feed the code space directly; 6 and 12 made here, 14 unused
    localparam logic [15:0] PIN_MASK = 16'hAFBF;
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_AUTOTUNE = 16'hF001;
    localparam logic [15:0] CODE_REMOTE_TRIP = 16'hF006;
    localparam logic [15:0] CODE_PRODUCT = 16'hFF06;
    // Timer base: one tick per tenth of a second
    localparam int CLK_MHZ = 25;
    localparam int TICK_NS = 100_000_000;
    localparam int TICK_CYCLES = TICK_NS / 1000 * CLK_MHZ;
endpackage
